//--- inc/loop_diag_pkg.sv
// constants, register map and mode codes for the loop-back diagnostic block
package loop_diag_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_STATUS        = 5'h00;
    localparam logic [4:0] ADDR_TX_CONTROL    = 5'h01;
    localparam logic [4:0] ADDR_LOOP_CONTROL  = 5'h04;
    localparam int         REG_WIDTH          = 5;
    localparam logic [4:0] REG_RESET_VALUE    = 5'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int STATUS_FAULT_BIT   = 0;
    localparam int STATUS_LOSS_BIT    = 3;
    localparam int TX_SHUTOFF_BIT     = 4;
    localparam int LOOP_LOCAL_BIT     = 1;
    localparam int LOOP_REMOTE_BIT    = 0;

    // ----------------------------------------------------------------
    // pin indices inside the synchroniser banks
    // ----------------------------------------------------------------
    localparam int PIN_HOST_MODE   = 0;
    localparam int PIN_LOCAL_SEL   = 1;
    localparam int PIN_REMOTE_SEL  = 2;
    localparam int PIN_SHUTOFF     = 3;
    localparam int PIN_REG_CLEAR   = 4;
    localparam int SYS_PIN_COUNT   = 5;

    localparam int LNK_RX_POS      = 0;
    localparam int LNK_RX_NEG      = 1;
    localparam int LNK_MON_POS     = 2;
    localparam int LNK_MON_NEG     = 3;
    localparam int LNK_MUTE        = 4;
    localparam int LNK_PIN_COUNT   = 5;

    // ----------------------------------------------------------------
    // drive monitor timing, in transmit line clock periods
    // ----------------------------------------------------------------
    localparam int         DRIVE_QUIET_PERIODS = 128;
    localparam logic [7:0] DRIVE_QUIET_LIMIT   = 8'(DRIVE_QUIET_PERIODS - 1);

    // ----------------------------------------------------------------
    // buffer
    // ----------------------------------------------------------------
    localparam int         BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL  = 2'h2;

    // ----------------------------------------------------------------
    // data path modes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_NORMAL  = 4'b0001,
        MODE_ANALOG  = 4'b0010,
        MODE_DIGITAL = 4'b0100,
        MODE_REMOTE  = 4'b1000
    } loop_mode_e;

endpackage : loop_diag_pkg

//--- hdl/loopback_diag_control.sv
// loop-back path selection, transmit shut-off and transmit drive monitor
//
// Overview of operation
// - analog local loop: line inputs ignored, driven line output looped into receive
// - analog local selected by local bit 1, remote bit 0 (register or pins)
// - analog local loop delivers nothing while the transmitter is shut off
// - either local loop mode forces the loss-of-signal condition
// - digital local loop: line inputs ignored, encoder output fed to decoder
// - digital local selected when local and remote bits are both 1
// - digital local loop keeps working while transmitter is shut off
// - remote loop: transmit inputs ignored, received data delivered and retransmitted
// - remote loop selected by remote bit 1, local bit 0
// - hardware mode: shut-off pin high disables driver, low enables it
// - host mode: shut-off pin ignored, transmit control bit 4 disables driver
// - fault flag low on transitions, high after 128 quiet line clocks
// - status bit 0 mirrors the drive fault flag
// - shut-off transmitter leaves the line outputs undriven
// - register clear input zeroes every command register bit
`timescale 1ns/100ps

module loopback_diag_control (
    // system clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // register port
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [4:0] reg_addr_i,
    input  wire logic [4:0] reg_wdata_i,
    output logic      [4:0] reg_rdata_o,
    // control pins
    input  wire logic       host_mode_select_i,
    input  wire logic       local_loop_select_i,
    input  wire logic       remote_loop_select_i,
    input  wire logic       transmit_shutoff_i,
    input  wire logic       register_clear_input_i,
    output logic            signal_loss_o,
    // link clock
    input  wire logic       transmit_line_clock,
    // transmit terminal stream
    input  wire logic       transmit_pos_data_in_i,
    input  wire logic       transmit_neg_data_in_i,
    input  wire logic       transmit_valid_i,
    output logic            transmit_ready_o,
    // line side
    input  wire logic       receive_line_pos_i,
    input  wire logic       receive_line_neg_i,
    input  wire logic       monitor_line_pos_i,
    input  wire logic       monitor_line_neg_i,
    input  wire logic       mute_on_signal_loss_i,
    output logic            transmit_line_pos_o,
    output logic            transmit_line_neg_o,
    output logic            transmit_line_oe_o,
    output logic            drive_fault_flag_o,
    // receive terminal stream
    output logic            receive_pos_data_out_o,
    output logic            receive_neg_data_out_o,
    output logic            receive_valid_o,
    input  wire logic       receive_ready_i
);

    // ----------------------------------------------------------------
    // pin synchronisers, system domain
    // ----------------------------------------------------------------
    logic [loop_diag_pkg::SYS_PIN_COUNT-1:0] sys_pins;
    logic [loop_diag_pkg::SYS_PIN_COUNT-1:0] sys_s1;
    logic [loop_diag_pkg::SYS_PIN_COUNT-1:0] sys_s2;
    logic [loop_diag_pkg::SYS_PIN_COUNT-1:0] sys_s3;
    logic [loop_diag_pkg::SYS_PIN_COUNT-1:0] sys_filt;

    assign sys_pins = {register_clear_input_i, transmit_shutoff_i, remote_loop_select_i,
                       local_loop_select_i, host_mode_select_i};

    genvar gi;
    generate
        for (gi = 0; gi < loop_diag_pkg::SYS_PIN_COUNT; gi++) begin : g_sys_sync
            always_ff @(posedge clk_sys_i) begin
                sys_s1[gi] <= sys_pins[gi];
                sys_s2[gi] <= sys_s1[gi];
                sys_s3[gi] <= sys_s2[gi];
                // a change counts only once the last two stages agree
                if (reset_i)
                    sys_filt[gi] <= 1'b0;
                else if (sys_s2[gi] == sys_s3[gi])
                    sys_filt[gi] <= sys_s3[gi];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // command registers
    // ----------------------------------------------------------------
    logic [4:0] transmit_control;
    logic [4:0] loop_and_rate_control;
    logic       reg_clear;
    logic       wr_tx_ctrl;
    logic       wr_loop_ctrl;
    logic       fault_sys;
    logic [4:0] status_word;
    logic [4:0] next_rdata;

    assign reg_clear    = reset_i || sys_filt[loop_diag_pkg::PIN_REG_CLEAR];
    assign wr_tx_ctrl   = reg_wr_i && (reg_addr_i == loop_diag_pkg::ADDR_TX_CONTROL);
    assign wr_loop_ctrl = reg_wr_i && (reg_addr_i == loop_diag_pkg::ADDR_LOOP_CONTROL);

    always_ff @(posedge clk_sys_i) begin
        if (reg_clear) begin
            transmit_control      <= loop_diag_pkg::REG_RESET_VALUE;
            loop_and_rate_control <= loop_diag_pkg::REG_RESET_VALUE;
        end else begin
            if (wr_tx_ctrl)
                transmit_control <= reg_wdata_i;
            if (wr_loop_ctrl)
                loop_and_rate_control <= reg_wdata_i;
        end
    end

    always_comb begin
        status_word = 5'h00;
        status_word[loop_diag_pkg::STATUS_FAULT_BIT] = fault_sys;
        status_word[loop_diag_pkg::STATUS_LOSS_BIT]  = signal_loss_o;
    end

    // unmapped and reserved registers read as zero
    assign next_rdata = (reg_addr_i == loop_diag_pkg::ADDR_STATUS)       ? status_word :
                        (reg_addr_i == loop_diag_pkg::ADDR_TX_CONTROL)   ? transmit_control :
                        (reg_addr_i == loop_diag_pkg::ADDR_LOOP_CONTROL) ? loop_and_rate_control :
                        5'h00;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i)
            reg_rdata_o <= 5'h00;
        else if (reg_rd_i)
            reg_rdata_o <= next_rdata;
    end

    // ----------------------------------------------------------------
    // mode selection, system domain
    // ----------------------------------------------------------------
    logic                     host_mode;
    logic                     sel_local;
    logic                     sel_remote;
    logic                     shutoff;
    loop_diag_pkg::loop_mode_e mode;
    loop_diag_pkg::loop_mode_e next_mode;

    assign host_mode  = sys_filt[loop_diag_pkg::PIN_HOST_MODE];
    assign sel_local  = host_mode ? loop_and_rate_control[loop_diag_pkg::LOOP_LOCAL_BIT]
                                  : sys_filt[loop_diag_pkg::PIN_LOCAL_SEL];
    assign sel_remote = host_mode ? loop_and_rate_control[loop_diag_pkg::LOOP_REMOTE_BIT]
                                  : sys_filt[loop_diag_pkg::PIN_REMOTE_SEL];
    // host mode ignores the shut-off pin altogether
    assign shutoff    = host_mode ? transmit_control[loop_diag_pkg::TX_SHUTOFF_BIT]
                                  : sys_filt[loop_diag_pkg::PIN_SHUTOFF];

    always_comb begin
        case ({sel_local, sel_remote})
            2'b10:   next_mode = loop_diag_pkg::MODE_ANALOG;
            2'b11:   next_mode = loop_diag_pkg::MODE_DIGITAL;
            2'b01:   next_mode = loop_diag_pkg::MODE_REMOTE;
            default: next_mode = loop_diag_pkg::MODE_NORMAL;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mode          <= loop_diag_pkg::MODE_NORMAL;
            signal_loss_o <= 1'b0;
        end else begin
            mode          <= next_mode;
            signal_loss_o <= (next_mode == loop_diag_pkg::MODE_ANALOG) ||
                             (next_mode == loop_diag_pkg::MODE_DIGITAL);
        end
    end

    // ----------------------------------------------------------------
    // crossings
    // ----------------------------------------------------------------
    // control bits cross one by one; a code is used only once two samples
    // agree, so a half-resolved mode change never steers the data path
    logic [4:0] ctl_sys;
    logic [4:0] ctl_x1;
    logic [4:0] ctl_x2;
    logic [4:0] ctl_x3;
    logic [4:0] ctl_lk;
    logic       lk_rst_x1;
    logic       lk_rst;
    logic       fault_x1;
    logic       fault_x2;

    assign ctl_sys = {!shutoff, mode};

    always_ff @(posedge transmit_line_clock) begin
        ctl_x1    <= ctl_sys;
        ctl_x2    <= ctl_x1;
        ctl_x3    <= ctl_x2;
        lk_rst_x1 <= reset_i;
        lk_rst    <= lk_rst_x1;
    end

    always_ff @(posedge transmit_line_clock) begin
        if (lk_rst)
            ctl_lk <= {1'b0, loop_diag_pkg::MODE_NORMAL};
        else if (ctl_x2 == ctl_x3)
            ctl_lk <= ctl_x2;
    end

    always_ff @(posedge clk_sys_i) begin
        fault_x1 <= drive_fault_flag_o;
        fault_x2 <= fault_x1;
    end
    assign fault_sys = fault_x2;

    // ----------------------------------------------------------------
    // pin synchronisers, link domain
    // ----------------------------------------------------------------
    logic [loop_diag_pkg::LNK_PIN_COUNT-1:0] lnk_pins;
    logic [loop_diag_pkg::LNK_PIN_COUNT-1:0] lnk_s1;
    logic [loop_diag_pkg::LNK_PIN_COUNT-1:0] lnk_s2;
    logic [loop_diag_pkg::LNK_PIN_COUNT-1:0] lnk_s3;
    logic [loop_diag_pkg::LNK_PIN_COUNT-1:0] lnk_filt;

    assign lnk_pins = {mute_on_signal_loss_i, monitor_line_neg_i, monitor_line_pos_i,
                       receive_line_neg_i, receive_line_pos_i};

    generate
        for (gi = 0; gi < loop_diag_pkg::LNK_PIN_COUNT; gi++) begin : g_lnk_sync
            always_ff @(posedge transmit_line_clock) begin
                lnk_s1[gi] <= lnk_pins[gi];
                lnk_s2[gi] <= lnk_s1[gi];
                lnk_s3[gi] <= lnk_s2[gi];
                if (lk_rst)
                    lnk_filt[gi] <= 1'b0;
                else if (lnk_s2[gi] == lnk_s3[gi])
                    lnk_filt[gi] <= lnk_s3[gi];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // data path, link domain
    // ----------------------------------------------------------------
    logic       lk_ana;
    logic       lk_dig;
    logic       lk_rem;
    logic       lk_drv_en;
    logic       lk_local;
    logic       tx_fire;
    logic [1:0] rx_line;
    logic [1:0] enc;
    logic [1:0] rx_src;
    logic       src_valid;
    logic       enc_vld;
    logic [1:0] fill_ahead;
    logic       buf_in_ready;
    logic       mute;

    assign lk_ana    = ctl_lk[1];
    assign lk_dig    = ctl_lk[2];
    assign lk_rem    = ctl_lk[3];
    assign lk_drv_en = ctl_lk[4];
    assign lk_local  = lk_ana || lk_dig;
    assign rx_line   = {lnk_filt[loop_diag_pkg::LNK_RX_POS], lnk_filt[loop_diag_pkg::LNK_RX_NEG]};

    // local loops take the terminal stream into the buffer, so a stalled
    // receiver holds off the transmitter; the digital loop also counts the
    // word still in the encoder flop, so a stall loses no word
    assign transmit_ready_o = lk_rem ? 1'b1 : lk_dig ? !fill_ahead[1] : lk_ana ? buf_in_ready : 1'b1;
    assign tx_fire          = transmit_valid_i && transmit_ready_o && !lk_rem;

    always_ff @(posedge transmit_line_clock) begin
        if (lk_rst) begin
            enc     <= 2'b00;
            enc_vld <= 1'b0;
        end else begin
            enc     <= tx_fire ? {transmit_pos_data_in_i, transmit_neg_data_in_i} : 2'b00;
            enc_vld <= tx_fire;
        end
    end

    always_ff @(posedge transmit_line_clock) begin
        if (lk_rst) begin
            transmit_line_pos_o <= 1'b0;
            transmit_line_neg_o <= 1'b0;
            transmit_line_oe_o  <= 1'b0;
        end else begin
            transmit_line_pos_o <= lk_rem ? rx_line[1] : enc[1];
            transmit_line_neg_o <= lk_rem ? rx_line[0] : enc[0];
            transmit_line_oe_o  <= lk_drv_en;
        end
    end

    // analog loop sees only what the driver really puts on the line
    assign rx_src = lk_ana ? (transmit_line_oe_o ? {transmit_line_pos_o, transmit_line_neg_o} : 2'b00)
                  : lk_dig ? enc
                  : rx_line;
    assign src_valid = lk_dig ? enc_vld : 1'b1;
    // forced loss in local loops mutes the data if the mute pin is left on
    assign mute      = lnk_filt[loop_diag_pkg::LNK_MUTE] && lk_local;

    // ----------------------------------------------------------------
    // two-entry receive buffer
    // ----------------------------------------------------------------
    logic [1:0] buf_mem [loop_diag_pkg::BUF_DEPTH];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] buf_count;
    logic       push;
    logic       pop;

    assign buf_in_ready    = (buf_count != loop_diag_pkg::BUF_FULL);
    assign receive_valid_o = (buf_count != 2'h0);
    assign push            = src_valid && buf_in_ready;
    assign pop             = receive_valid_o && receive_ready_i;
    assign fill_ahead      = 2'(buf_count + {1'b0, enc_vld} - {1'b0, pop});
    assign receive_pos_data_out_o = buf_mem[rd_ptr][1];
    assign receive_neg_data_out_o = buf_mem[rd_ptr][0];

    always_ff @(posedge transmit_line_clock) begin
        if (lk_rst) begin
            buf_mem[0] <= 2'b00;
            buf_mem[1] <= 2'b00;
            wr_ptr     <= 1'b0;
            rd_ptr     <= 1'b0;
            buf_count  <= 2'h0;
        end else begin
            if (push)
                buf_mem[wr_ptr] <= mute ? 2'b00 : rx_src;
            wr_ptr    <= wr_ptr ^ push;
            rd_ptr    <= rd_ptr ^ pop;
            buf_count <= 2'(buf_count + {1'b0, push} - {1'b0, pop});
        end
    end

    // ----------------------------------------------------------------
    // transmit drive monitor
    // ----------------------------------------------------------------
    logic [1:0] mon_prev;
    logic [1:0] mon_now;
    logic       mon_edge;
    logic [7:0] quiet_cnt;

    assign mon_now  = {lnk_filt[loop_diag_pkg::LNK_MON_POS], lnk_filt[loop_diag_pkg::LNK_MON_NEG]};
    assign mon_edge = (mon_now != mon_prev);

    always_ff @(posedge transmit_line_clock) begin
        if (lk_rst) begin
            mon_prev           <= 2'b00;
            quiet_cnt          <= 8'h00;
            drive_fault_flag_o <= 1'b0;
        end else begin
            mon_prev <= mon_now;
            if (mon_edge) begin
                quiet_cnt          <= 8'h00;
                drive_fault_flag_o <= 1'b0;
            end else if (quiet_cnt == loop_diag_pkg::DRIVE_QUIET_LIMIT) begin
                drive_fault_flag_o <= 1'b1;
            end else begin
                quiet_cnt <= quiet_cnt + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_analog_loop_path: assert property (@(posedge transmit_line_clock) disable iff (lk_rst)
        lk_ana && transmit_line_oe_o |-> rx_src == {transmit_line_pos_o, transmit_line_neg_o})
        else $error("analog loop does not return the driven line data");

    a_analog_mode_decode: assert property (@(posedge clk_sys_i) disable iff (reg_clear)
        host_mode && loop_and_rate_control[1:0] == 2'b10 |=> mode == loop_diag_pkg::MODE_ANALOG)
        else $error("analog loop not selected from loop control");

    a_analog_needs_driver: assert property (@(posedge transmit_line_clock) disable iff (lk_rst)
        lk_ana && !transmit_line_oe_o |-> rx_src == 2'b00)
        else $error("analog loop delivers data with the driver off");

    a_local_forces_loss: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ##1 (mode == loop_diag_pkg::MODE_ANALOG || mode == loop_diag_pkg::MODE_DIGITAL) |-> signal_loss_o)
        else $error("local loop without loss of signal");

    a_digital_loop_path: assert property (@(posedge transmit_line_clock) disable iff (lk_rst)
        lk_dig |-> rx_src == enc)
        else $error("digital loop does not feed encoder output to receive");

    a_digital_no_drop: assert property (@(posedge transmit_line_clock) disable iff (lk_rst)
        lk_dig ##1 (lk_dig && enc_vld) |-> buf_in_ready)
        else $error("digital loop word finds the receive buffer full");

    a_remote_retransmit: assert property (@(posedge transmit_line_clock) disable iff (lk_rst)
        lk_rem ##1 lk_rem |-> {transmit_line_pos_o, transmit_line_neg_o} == $past(rx_line))
        else $error("remote loop does not retransmit received data");

    a_shutoff_floats: assert property (@(posedge transmit_line_clock) disable iff (lk_rst)
        !lk_drv_en |=> !transmit_line_oe_o)
        else $error("line driven while transmitter shut off");

    a_fault_after_quiet: assert property (@(posedge transmit_line_clock) disable iff (lk_rst)
        $rose(drive_fault_flag_o) |-> $past(quiet_cnt) == loop_diag_pkg::DRIVE_QUIET_LIMIT)
        else $error("drive fault raised at the wrong quiet count");

    a_fault_clear_on_edge: assert property (@(posedge transmit_line_clock) disable iff (lk_rst)
        mon_edge |=> !drive_fault_flag_o)
        else $error("drive fault kept high after a transition");

    a_status_mirror: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        reg_rd_i && reg_addr_i == loop_diag_pkg::ADDR_STATUS |=> reg_rdata_o[0] == $past(fault_sys))
        else $error("status bit 0 does not mirror the drive fault");

    a_clear_zeroes_regs: assert property (@(posedge clk_sys_i)
        sys_filt[loop_diag_pkg::PIN_REG_CLEAR] |=> transmit_control == 5'h00 && loop_and_rate_control == 5'h00)
        else $error("register clear left a command bit set");

    c_digital_with_shutoff: cover property (@(posedge transmit_line_clock) disable iff (lk_rst)
        lk_dig && !lk_drv_en && push);
    c_remote_loop: cover property (@(posedge transmit_line_clock) disable iff (lk_rst)
        lk_rem && push);
    c_fault_raised: cover property (@(posedge transmit_line_clock) disable iff (lk_rst)
        $rose(drive_fault_flag_o));
    c_buffer_full_stall: cover property (@(posedge transmit_line_clock) disable iff (lk_rst)
        lk_local && !buf_in_ready && transmit_valid_i);

endmodule : loopback_diag_control

//--- sim/framer_model.sv
// terminal framer model: transmit word source and receive word sink
`timescale 1ns/100ps
module framer_model (
    // link clock
    input  wire logic       link_clk_i,
    // bench control
    input  wire logic [1:0] word_i,
    input  wire logic       stall_i,
    // transmit stream
    output logic            tx_pos_o,
    output logic            tx_neg_o,
    output logic            tx_valid_o,
    input  wire logic       tx_ready_i,
    // receive stream
    input  wire logic       rx_pos_i,
    input  wire logic       rx_neg_i,
    input  wire logic       rx_valid_i,
    output logic            rx_ready_o,
    output logic [1:0]      rx_last_o
);
    assign rx_ready_o = !stall_i;
    initial begin
        tx_valid_o = 1'b0;
        {tx_pos_o, tx_neg_o} = 2'h0;
        rx_last_o = 2'h0;
    end
    // a word stays offered until the block takes it
    always @(posedge link_clk_i) begin
        tx_valid_o <= 1'b1;
        if (!tx_valid_o || tx_ready_i) begin
            {tx_pos_o, tx_neg_o} <= word_i;
        end
        if (rx_valid_i && !stall_i) begin
            rx_last_o <= {rx_pos_i, rx_neg_i};
        end
    end
endmodule : framer_model

//--- sim/test_loopback_diag_control.sv
// self-checking bench for the loop-back diagnostic block
`timescale 1ns/100ps
module test_loopback_diag_control;
    logic clk_sys_i = 0, lclk = 0, reset_i = 1, wr = 0, rd = 0, hm = 1, llp = 0, rlp = 0, off = 0, clr = 0;
    logic [4:0] addr = 0, wd = 0, rdata;
    logic [1:0] rl = 0, mon = 0, word = 2'h2, last;
    logic stall = 0, mon_run = 1, mt = 0, mph = 0, tp, tn, tv, tr, rp, rn, rv, rr, loss, lp, ln, oe, fault;
    int n_fail = 0, num_checks = 0;
    initial forever #10 clk_sys_i = ~clk_sys_i;
    initial begin
        #7;
        forever #80 lclk = ~lclk;
    end
    // transitions every other line clock, slow enough to pass the pin filter
    always @(posedge lclk) begin
        mph <= ~mph;
        if (mon_run && mph) mon <= ~mon;
    end
    loopback_diag_control u_loopback_diag_control (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .host_mode_select_i(hm),
        .local_loop_select_i(llp), .remote_loop_select_i(rlp), .transmit_shutoff_i(off),
        .register_clear_input_i(clr), .signal_loss_o(loss), .transmit_line_clock(lclk),
        .transmit_pos_data_in_i(tp), .transmit_neg_data_in_i(tn), .transmit_valid_i(tv), .transmit_ready_o(tr),
        .receive_line_pos_i(rl[1]), .receive_line_neg_i(rl[0]), .monitor_line_pos_i(mon[1]),
        .monitor_line_neg_i(mon[0]), .mute_on_signal_loss_i(mt), .transmit_line_pos_o(lp),
        .transmit_line_neg_o(ln), .transmit_line_oe_o(oe), .drive_fault_flag_o(fault),
        .receive_pos_data_out_o(rp), .receive_neg_data_out_o(rn), .receive_valid_o(rv), .receive_ready_i(rr));
    framer_model u_framer_model (.link_clk_i(lclk), .word_i(word), .stall_i(stall), .tx_pos_o(tp),
        .tx_neg_o(tn), .tx_valid_o(tv), .tx_ready_i(tr), .rx_pos_i(rp), .rx_neg_i(rn), .rx_valid_i(rv),
        .rx_ready_o(rr), .rx_last_o(last));
    task automatic chk(string what, logic [4:0] got, logic [4:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wreg(logic [4:0] a, logic [4:0] d);
        @(posedge clk_sys_i);
        wr <= 1;
        addr <= a;
        wd <= d;
        @(posedge clk_sys_i);
        wr <= 0;
    endtask : wreg
    task automatic rreg(logic [4:0] a, logic [4:0] exp);
        @(posedge clk_sys_i);
        rd <= 1;
        addr <= a;
        @(posedge clk_sys_i);
        rd <= 0;
        #1 chk("rdata", rdata, exp);
    endtask : rreg
    // pins and mode cross two domains, so allow several link periods
    task automatic settle();
        repeat (100) @(posedge clk_sys_i);
        #1;
    endtask : settle
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic t_paths();
        rreg(5'h01, 5'h00);
        rl <= 2'h1;
        settle();
        chk("line", {lp, ln}, 5'h2);
        chk("rx", last, 5'h1);
        wreg(5'h04, 5'h02);
        settle();
        chk("loss", loss, 5'h1);
        chk("rx", last, 5'h2);
        rreg(5'h00, 5'h08);
        wreg(5'h01, 5'h10);
        settle();
        chk("oe", oe, 5'h0);
        chk("rx", last, 5'h0);
        wreg(5'h04, 5'h03);
        settle();
        chk("rx", last, 5'h2);
        chk("loss", loss, 5'h1);
        mt <= 1;
        settle();
        chk("muted", last, 5'h0);
        mt <= 0;
        stall <= 1;
        settle();
        chk("ready", {tr, rv}, 5'h1);
        stall <= 0;
        settle();
        chk("ready", tr, 5'h1);
        wreg(5'h01, 5'h00);
        wreg(5'h04, 5'h01);
        settle();
        chk("line", {oe, lp, ln, loss}, 5'h0a);
        chk("rx", last, 5'h1);
        $display("test paths done");
    endtask : t_paths
    task automatic t_pins();
        wreg(5'h04, 5'h00);
        hm <= 0;
        llp <= 1;
        off <= 1;
        settle();
        chk("pins", {loss, oe}, 5'h2);
        off <= 0;
        llp <= 0;
        settle();
        chk("pins", {loss, oe}, 5'h1);
        hm <= 1;
        off <= 1;
        settle();
        chk("oe", oe, 5'h1);
        off <= 0;
        wreg(5'h04, 5'h03);
        wreg(5'h01, 5'h10);
        rreg(5'h04, 5'h03);
        clr <= 1;
        settle();
        clr <= 0;
        rreg(5'h01, 5'h00);
        rreg(5'h04, 5'h00);
        settle();
        chk("oe", oe, 5'h1);
        $display("test pins done");
    endtask : t_pins
    task automatic t_monitor();
        mon_run <= 0;
        repeat (92) @(posedge lclk);
        #1 chk("fault", fault, 5'h0);
        repeat (70) @(posedge lclk);
        #1 chk("fault", fault, 5'h1);
        rreg(5'h00, 5'h01);
        mon_run <= 1;
        repeat (10) @(posedge lclk);
        #1 chk("fault", fault, 5'h0);
        $display("test monitor done");
    endtask : t_monitor
    initial begin
        #400000;
        n_fail++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 0;
        settle();
        t_paths();
        t_pins();
        t_monitor();
        close_out();
    end
endmodule : test_loopback_diag_control
